// ==== pkg/sdiag_pkg.sv ====
// sdiag_pkg: register map, field layout, reset values and timing counts
// of the sleep and diagnostic status register bank.
// assumes a 16-bit serial word protocol with a 50 MHz core clock.
package sdiag_pkg;
   // register byte addresses on the serial link
   localparam logic [6:0] SDIAG_ADDR_SLEEP = 7'h24;
   localparam logic [6:0] SDIAG_ADDR_FLAGS = 7'h26;
   localparam logic [6:0] SDIAG_ADDR_LOT1 = 7'h32;
   localparam logic [6:0] SDIAG_ADDR_LOT2 = 7'h34;
   localparam logic [6:0] SDIAG_ADDR_LOT3 = 7'h36;
   localparam logic [6:0] SDIAG_ADDR_PROD = 7'h38;
   localparam logic [6:0] SDIAG_ADDR_SERIAL = 7'h3A;
   // error flag bit positions
   localparam int SDIAG_BIT_SUPPLY = 0;
   localparam int SDIAG_BIT_FLASHUPD = 2;
   localparam int SDIAG_BIT_SPIERR = 3;
   localparam int SDIAG_BIT_RANGE = 4;
   localparam int SDIAG_BIT_SELFTEST = 5;
   localparam int SDIAG_BIT_CHECKSUM = 6;
   localparam int SDIAG_BIT_ALARM1 = 8;
   localparam int SDIAG_BIT_ALARM2 = 9;
   localparam logic [15:0] SDIAG_FLAGS_USED = 16'h037D;
   // reset values and field constants
   localparam logic [15:0] SDIAG_FLAGS_RST = 16'h0000;
   localparam logic [7:0] SDIAG_SLEEP_RST = 8'h00;
   localparam logic [7:0] SDIAG_SLEEP_FOREVER = 8'hFF;
   localparam logic [13:0] SDIAG_SERIAL_MASK = 14'h3FFF;
   localparam int SDIAG_WORD_BITS = 16;
   // timing: half a second per sleep count at 50 MHz
   localparam int SDIAG_CLK_HZ = 50000000;
   localparam int SDIAG_SLEEP_STEP_MS = 500;
   localparam int SDIAG_SLEEP_STEP_CYC = SDIAG_CLK_HZ / 1000 * SDIAG_SLEEP_STEP_MS;
endpackage : sdiag_pkg

// ==== rtl/sdiag_sync.sv ====
// sdiag_sync: two flip-flop synchroniser for a group of pin inputs.
// assumes the inputs are asynchronous to clk_i.
`timescale 1ns/1ps
module sdiag_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [WIDTH-1:0] rst_val_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_q <= rst_val_i; // idle level, so no false edge after reset
         sync_o <= rst_val_i;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule : sdiag_sync

// ==== rtl/sdiag_shift.sv ====
// sdiag_shift: serial word engine; counts clock edges per frame, shifts in
// 16-bit words and shifts out the reply word loaded at each word boundary.
// assumes synchronised chip select and serial clock, mode 3 timing.
`timescale 1ns/1ps
module sdiag_shift
   import sdiag_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic mosi_i,
   input wire logic [15:0] reply_i,
   output logic [15:0] word_o,
   output logic word_valid_o,
   output logic frame_bad_o,
   output logic frame_start_o,
   output logic miso_o
);
   logic sclk_q;
   logic cs_n_q;
   logic [3:0] bit_cnt_q;
   logic [15:0] shin_q;
   logic [15:0] shout_q;
   logic rise;
   logic fall;

   assign rise = sclk_i & ~sclk_q & ~cs_n_i;
   assign fall = ~sclk_i & sclk_q & ~cs_n_i;

   // edge history
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sclk_q <= 1'b1;
         cs_n_q <= 1'b1;
      end else begin
         sclk_q <= sclk_i;
         cs_n_q <= cs_n_i;
      end
   end

   // input shifting on rising edges, word completion every 16 edges
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || cs_n_i) begin
         bit_cnt_q <= 4'h0;
         shin_q <= 16'h0000;
         word_valid_o <= 1'b0;
      end else begin
         word_valid_o <= 1'b0;
         if (rise) begin
            shin_q <= {shin_q[14:0], mosi_i};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'hF) begin
               word_o <= {shin_q[14:0], mosi_i};
               word_valid_o <= 1'b1;
            end
         end
      end
   end

   // output shifting; reply loaded at frame start and each word boundary
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         shout_q <= 16'h0000;
         miso_o <= 1'b0;
      end else if (cs_n_q & ~cs_n_i) begin
         shout_q <= {reply_i[14:0], 1'b0};
         miso_o <= reply_i[15];
      end else if (fall) begin
         if (bit_cnt_q == 4'h0) begin
            shout_q <= {reply_i[14:0], 1'b0};
            miso_o <= reply_i[15];
         end else begin
            shout_q <= {shout_q[14:0], 1'b0};
            miso_o <= shout_q[15];
         end
      end
   end

   // frame end with a partial word, and frame start pulse
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         frame_bad_o <= 1'b0;
         frame_start_o <= 1'b0;
      end else begin
         frame_bad_o <= ~cs_n_q & cs_n_i & (bit_cnt_q != 4'h0);
         frame_start_o <= cs_n_q & ~cs_n_i;
      end
   end
endmodule : sdiag_shift

// ==== rtl/sdiag_top.sv ====
// sdiag_top: sleep control and diagnostic status register bank of a
// rate sensor, reached over a 16-clock-per-word serial port.
// assumes serial pins and reset pin asynchronous to clk_i; condition inputs
// come from sensor logic on clk_i; sample_tick_i marks the end of a sample.
`timescale 1ns/1ps

module sdiag_top
   import sdiag_pkg::*;
#(
   parameter logic [15:0] PRODUCT_CODE = 16'h1234, // arbitrary value
   parameter logic [15:0] LOT_CODE_1 = 16'h0001, // arbitrary value
   parameter logic [15:0] LOT_CODE_2 = 16'h0002, // arbitrary value
   parameter logic [15:0] LOT_CODE_3 = 16'h0003, // arbitrary value
   parameter logic [13:0] SERIAL_NUMBER = 14'h0001, // arbitrary value
   parameter int SLEEP_STEP_CYC = SDIAG_SLEEP_STEP_CYC
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic rst_pin_n_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic mosi_i,
   output logic miso_o,
   input wire logic sample_tick_i,
   input wire logic supply_low_i,
   input wire logic flash_fail_i,
   input wire logic over_range_i,
   input wire logic self_test_fail_i,
   input wire logic checksum_fail_i,
   input wire logic alarm1_i,
   input wire logic alarm2_i,
   output logic asleep_o,
   output logic sleep_forever_o
);
   // ==========================================================
   // elaboration checks
   if (SLEEP_STEP_CYC < 1 || SERIAL_NUMBER == 14'h0000) begin : g_bad_param
      $error("sdiag_top: bad parameter");
   end

   // ==========================================================
   // pin synchronisers
   logic [3:0] pins_sync;
   logic cs_n_s;
   logic sclk_s;
   logic mosi_s;
   logic rst_pin_n_s;

   sdiag_sync #(.WIDTH(4)) u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .rst_val_i(4'hF),
      .async_i({cs_n_i, sclk_i, mosi_i, rst_pin_n_i}),
      .sync_o(pins_sync)
   );
   assign {cs_n_s, sclk_s, mosi_s, rst_pin_n_s} = pins_sync;

   // ==========================================================
   // serial word engine
   logic [15:0] word;
   logic word_valid;
   logic frame_bad;
   logic frame_start;
   logic [15:0] reply_q;
   logic miso_int;

   sdiag_shift u_shift (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .cs_n_i(cs_n_s),
      .sclk_i(sclk_s),
      .mosi_i(mosi_s),
      .reply_i(reply_q),
      .word_o(word),
      .word_valid_o(word_valid),
      .frame_bad_o(frame_bad),
      .frame_start_o(frame_start),
      .miso_o(miso_int)
   );

   // ==========================================================
   // command decode: bit15 write, [14:8] address, [7:0] data
   logic is_write;
   logic [6:0] cmd_addr;
   logic rd_flags;
   logic wr_sleep;
   logic rst_pin_q;
   logic rst_pulse_done;

   assign is_write = word[15];
   assign cmd_addr = {word[14:9], 1'b0};
   assign rd_flags = word_valid & ~is_write & (cmd_addr == SDIAG_ADDR_FLAGS);
   assign wr_sleep = word_valid & is_write & (word[14:8] == SDIAG_ADDR_SLEEP);

   // reset pin released after a low pulse
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rst_pin_q <= 1'b1;
      end else begin
         rst_pin_q <= rst_pin_n_s;
      end
   end
   assign rst_pulse_done = ~rst_pin_q & rst_pin_n_s;

   // ==========================================================
   // sleep control
   typedef enum logic [1:0] {SDIAG_AWAKE, SDIAG_TIMED, SDIAG_FOREVER} sdiag_sleep_e;
   sdiag_sleep_e sleep_state_q;
   logic [7:0] sleep_reg_q;
   logic [7:0] sleep_left_q;
   logic [31:0] step_cnt_q;
   logic wake_event;

   assign wake_event = frame_start | rst_pulse_done;

   // sleep register storage
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sleep_reg_q <= SDIAG_SLEEP_RST;
      end else if (wr_sleep) begin
         sleep_reg_q <= word[7:0];
      end
   end

   // sleep state machine
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sleep_state_q <= SDIAG_AWAKE;
         sleep_left_q <= 8'h00;
         step_cnt_q <= 32'h0;
      end else begin
         case (sleep_state_q)
            SDIAG_AWAKE: begin
               step_cnt_q <= 32'h0;
               if (wr_sleep && word[7:0] == SDIAG_SLEEP_FOREVER) begin
                  sleep_state_q <= SDIAG_FOREVER;
               end else if (wr_sleep && word[7:0] != 8'h00) begin
                  sleep_state_q <= SDIAG_TIMED;
                  sleep_left_q <= word[7:0];
               end
            end
            SDIAG_TIMED: begin
               if (wake_event) begin
                  sleep_state_q <= SDIAG_AWAKE;
               end else if (step_cnt_q == 32'(SLEEP_STEP_CYC - 1)) begin
                  step_cnt_q <= 32'h0;
                  sleep_left_q <= sleep_left_q - 8'h01;
                  if (sleep_left_q == 8'h01) begin
                     sleep_state_q <= SDIAG_AWAKE;
                  end
               end else begin
                  step_cnt_q <= step_cnt_q + 32'h1;
               end
            end
            SDIAG_FOREVER: begin
               if (wake_event) begin
                  sleep_state_q <= SDIAG_AWAKE;
               end
            end
            default: sleep_state_q <= SDIAG_AWAKE;
         endcase
      end
   end

   // sleep status outputs
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         asleep_o <= 1'b0;
         sleep_forever_o <= 1'b0;
      end else begin
         asleep_o <= (sleep_state_q != SDIAG_AWAKE);
         sleep_forever_o <= (sleep_state_q == SDIAG_FOREVER);
      end
   end

   // ==========================================================
   // error flags
   logic [15:0] flags_q;
   logic [15:0] cond;

   // conditions sampled at sample end; spi error is an event
   always_comb begin
      cond = 16'h0000;
      cond[SDIAG_BIT_FLASHUPD] = flash_fail_i;
      cond[SDIAG_BIT_RANGE] = over_range_i;
      cond[SDIAG_BIT_SELFTEST] = self_test_fail_i;
      cond[SDIAG_BIT_CHECKSUM] = checksum_fail_i;
      cond[SDIAG_BIT_ALARM1] = alarm1_i;
      cond[SDIAG_BIT_ALARM2] = alarm2_i;
   end

   // sticky flags except supply, which follows supply_low_i: read clears, sample end (spi error: partial frame) re-sets, set wins over clear
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         flags_q <= SDIAG_FLAGS_RST;
      end else begin
         for (int i = 0; i < 16; i++) begin
            if (SDIAG_FLAGS_USED[i] == 1'b0) flags_q[i] <= 1'b0;
            else if (i == SDIAG_BIT_SUPPLY) flags_q[i] <= supply_low_i;
            else if (i == SDIAG_BIT_SPIERR && frame_bad) flags_q[i] <= 1'b1;
            else if (i != SDIAG_BIT_SPIERR && sample_tick_i && cond[i]) flags_q[i] <= 1'b1;
            else if (rd_flags) flags_q[i] <= 1'b0;
            else flags_q[i] <= flags_q[i];
         end
      end
   end

   // ==========================================================
   // reply word for the next 16 clocks
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         reply_q <= 16'h0000;
      end else if (word_valid && !is_write) begin
         case (cmd_addr)
            SDIAG_ADDR_SLEEP: reply_q <= {8'h00, sleep_reg_q};
            SDIAG_ADDR_FLAGS: reply_q <= flags_q;
            SDIAG_ADDR_LOT1: reply_q <= LOT_CODE_1;
            SDIAG_ADDR_LOT2: reply_q <= LOT_CODE_2;
            SDIAG_ADDR_LOT3: reply_q <= LOT_CODE_3;
            SDIAG_ADDR_PROD: reply_q <= PRODUCT_CODE;
            SDIAG_ADDR_SERIAL: reply_q <= {2'b00, SERIAL_NUMBER & SDIAG_SERIAL_MASK};
            default: reply_q <= 16'h0000;
         endcase
      end
   end

   // miso registered once more after the shift engine register
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         miso_o <= 1'b0;
      end else begin
         miso_o <= miso_int;
      end
   end
endmodule : sdiag_top

// ==== tb/sdiag_asserts.sv ====
// sdiag_asserts: port-level timing checks of the sleep and status bank.
// assumes binding onto sdiag_top; the sleep step count comes through the bind.
`timescale 1ns/1ps
module sdiag_asserts #(
   parameter int SLEEP_STEP_CYC = 10
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic rst_pin_n_i,
   input wire logic cs_n_i,
   input wire logic asleep_o,
   input wire logic sleep_forever_o
);
   int unsigned timed_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // ===========================================
   // cycles spent in the current timed sleep
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !asleep_o || sleep_forever_o) begin
         timed_q <= 0;
      end else begin
         timed_q <= timed_q + 1;
      end
   end
   AST_FOREVER_ASLEEP: assert property (sleep_forever_o |-> asleep_o)
      else $error("indefinite sleep without sleep");
   AST_RESET_IDLE: assert property ($fell(sys_rst_i) |-> !asleep_o && !sleep_forever_o)
      else $error("sleep outputs set after reset");
   AST_CS_WAKE: assert property ($fell(cs_n_i) && asleep_o |-> ##[1:6] !asleep_o)
      else $error("select fall did not wake");
   AST_PIN_WAKE: assert property ($rose(rst_pin_n_i) && asleep_o |-> ##[1:6] !asleep_o)
      else $error("reset pin pulse did not wake");
   AST_FOREVER_HOLDS: assert property ((cs_n_i && rst_pin_n_i)[*8] ##0 sleep_forever_o
      |=> sleep_forever_o)
      else $error("indefinite sleep ended without wake event");
   AST_NO_SELF_SLEEP: assert property ((cs_n_i && !asleep_o)[*8] |=> !asleep_o)
      else $error("sleep entered without a write");
   AST_FOREVER_ENTRY: assert property ($rose(sleep_forever_o) |-> $rose(asleep_o))
      else $error("indefinite sleep entered from sleep");
   AST_FOREVER_EXIT: assert property ($fell(sleep_forever_o) |-> $fell(asleep_o))
      else $error("indefinite sleep left without waking");
   AST_TIMED_BOUND: assert property (timed_q <= 254 * SLEEP_STEP_CYC + 8)
      else $error("timed sleep overran its longest count");
   // main scenarios seen
   C_FOREVER: cover property ($rose(sleep_forever_o));
   C_TIMED: cover property ($rose(asleep_o) && !sleep_forever_o);
   C_EXPIRY: cover property ($fell(asleep_o) && cs_n_i && rst_pin_n_i);
endmodule : sdiag_asserts

bind sdiag_top sdiag_asserts #(.SLEEP_STEP_CYC(SLEEP_STEP_CYC)) u_asserts (.clk_i(clk_i),
   .sys_rst_i(sys_rst_i), .rst_pin_n_i(rst_pin_n_i), .cs_n_i(cs_n_i), .asleep_o(asleep_o),
   .sleep_forever_o(sleep_forever_o));

// ==== tb/sdiag_host.sv ====
// sdiag_host: behavioural serial master standing for the host processor.
// assumes clk_i is the 50 MHz core clock; serial clock period is 8 of its cycles.
`timescale 1ns/1ps
module sdiag_host (
   input wire logic clk_i,
   input wire logic miso_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic mosi_o,
   output logic [15:0] word_o,
   output logic done_o
);
   // idle lines: select high, serial clock high
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b1;
      mosi_o = 1'b0;
      word_o = 16'h0000;
      done_o = 1'b0;
   end
   // ===========================================
   // one frame of nbits clocks, msb first, data taken on rising edge
   task automatic xfer(input logic [15:0] w, input int nbits);
      logic [15:0] r;
      r = 16'h0000;
      @(negedge clk_i);
      cs_n_o = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         repeat (4) @(negedge clk_i);
         sclk_o = 1'b0;
         mosi_o = w[15 - (i % 16)];
         repeat (4) @(negedge clk_i);
         sclk_o = 1'b1;
         r = {r[14:0], miso_i};
      end
      repeat (4) @(negedge clk_i);
      cs_n_o = 1'b1;
      mosi_o = ~mosi_o; // released line does not keep its value
      word_o = r;
      done_o = (nbits == 16);
      @(negedge clk_i);
      done_o = 1'b0;
      repeat (4) @(negedge clk_i);
   endtask : xfer
   // select low with no clocks, a wake event
   task automatic pulse_cs();
      @(negedge clk_i);
      cs_n_o = 1'b0;
      repeat (10) @(negedge clk_i);
      cs_n_o = 1'b1;
      repeat (4) @(negedge clk_i);
   endtask : pulse_cs
endmodule : sdiag_host

// ==== tb/sleep_and_diag_status_bench.sv ====
// sleep_and_diag_status_bench: self-checking bench of the sleep and status bank.
// assumes the short sleep step below; replies are checked against queued notes.
`timescale 1ns/1ps
module sleep_and_diag_status_bench;
   import sdiag_pkg::*;
   localparam int STEP = 10;
   localparam logic [15:0] PROD = 16'hB00C; // arbitrary value
   localparam logic [13:0] SER = 14'h0123; // arbitrary value
   logic clk, rst, rst_pin_n, cs_n, sclk, mosi, miso, tick, asleep, sleep_fv, hdone;
   logic [6:0] cond;
   logic [15:0] hword;
   logic [31:0] nt;
   logic [31:0] notes[$];
   int errors, num_checks, run, dur;
   int seed = 32'h16582605;
   sdiag_top #(.PRODUCT_CODE(PROD), .LOT_CODE_1(16'h1111), .LOT_CODE_2(16'h2222),
      .LOT_CODE_3(16'h3333), .SERIAL_NUMBER(SER), .SLEEP_STEP_CYC(STEP)) u_dut (.clk_i(clk),
      .sys_rst_i(rst), .rst_pin_n_i(rst_pin_n), .cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi),
      .miso_o(miso), .sample_tick_i(tick), .supply_low_i(cond[0]), .flash_fail_i(cond[1]),
      .over_range_i(cond[2]), .self_test_fail_i(cond[3]), .checksum_fail_i(cond[4]),
      .alarm1_i(cond[5]), .alarm2_i(cond[6]), .asleep_o(asleep), .sleep_forever_o(sleep_fv));
   sdiag_host u_host (.clk_i(clk), .miso_i(miso), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi),
      .word_o(hword), .done_o(hdone));
   // ===========================================
   task automatic results();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   task automatic chk_word(input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR reply word expected %h seen %h", exp, got);
      end
   endtask : chk_word
   task automatic chk_state(input string what, input logic [1:0] exp, input logic [1:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_state
   // read command word, then a filler word whose reply is noted
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      notes.push_back(32'h0);
      u_host.xfer({1'b0, a, 8'h00}, 16);
      notes.push_back({16'hFFFF, exp});
      u_host.xfer(16'h0000, 16);
   endtask : rd
   function automatic logic [15:0] flags_of(input logic [6:0] c, input logic spi);
      return {6'h00, c[6], c[5], 1'b0, c[4], c[3], c[2], spi, c[1], 1'b0, c[0]};
   endfunction : flags_of
   task automatic pulse_tick();
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      repeat (4) @(negedge clk);
   endtask : pulse_tick
   // timed sleep of n steps; length measured by the watcher below
   task automatic nap(input logic [7:0] n);
      int cyc;
      u_host.xfer({1'b1, SDIAG_ADDR_SLEEP, n}, 16);
      if (n == 8'h00) begin
         repeat (30) @(negedge clk);
         chk_state("zero sleep", 2'b00, {asleep, sleep_fv});
      end else begin
         for (cyc = 0; asleep === 1'b1 && cyc < 3000; cyc++) @(negedge clk);
         // let the watcher record the finished run first
         @(negedge clk);
         if (cyc >= 3000) begin
            errors++;
            results();
         end else begin
            chk_state("timed length", 2'b01, {1'b0, dur >= n * STEP && dur <= n * STEP + 3});
            chk_state("resumed", 2'b00, {asleep, sleep_fv});
         end
      end
   endtask : nap
   // clock and timed-sleep length watcher
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (asleep === 1'b1 && sleep_fv !== 1'b1) begin
         run++;
      end else begin
         if (run != 0) dur = run;
         run = 0;
      end
   end
   // reply watcher: oldest note against each finished word
   always @(posedge clk) begin
      if (hdone === 1'b1 && notes.size() > 0) begin
         nt = notes.pop_front();
         if (nt[31:16] != 16'h0) chk_word(nt[15:0], hword & nt[31:16]);
      end
   end
   // main sequence
   initial begin
      rst = 1'b1;
      rst_pin_n = 1'b1;
      tick = 1'b0;
      cond = 7'h00;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      rd(SDIAG_ADDR_FLAGS, SDIAG_FLAGS_RST);
      rd(SDIAG_ADDR_PROD, PROD);
      rd(SDIAG_ADDR_LOT1, 16'h1111);
      rd(SDIAG_ADDR_LOT2, 16'h2222);
      rd(SDIAG_ADDR_LOT3, 16'h3333);
      rd(SDIAG_ADDR_SERIAL, {2'b00, SER});
      rd(7'h40, 16'h0000);
      repeat (3) begin
         cond = 7'($random(seed));
         pulse_tick();
         rd(SDIAG_ADDR_FLAGS, flags_of(cond, 1'b0));
         pulse_tick();
         rd(SDIAG_ADDR_FLAGS, flags_of(cond, 1'b0));
         cond = 7'h00;
         rd(SDIAG_ADDR_FLAGS, 16'h0000);
      end
      cond = 7'h01;
      pulse_tick();
      cond = 7'h00;
      repeat (5) @(negedge clk);
      rd(SDIAG_ADDR_FLAGS, 16'h0000);
      u_host.xfer(16'hFFFF, 12);
      pulse_tick();
      rd(SDIAG_ADDR_FLAGS, 16'h0008);
      u_host.xfer({1'b1, SDIAG_ADDR_SLEEP, SDIAG_SLEEP_FOREVER}, 16);
      repeat (300) @(negedge clk);
      chk_state("indefinite sleep", 2'b11, {asleep, sleep_fv});
      u_host.pulse_cs();
      chk_state("select wake", 2'b00, {asleep, sleep_fv});
      u_host.xfer({1'b1, SDIAG_ADDR_SLEEP, SDIAG_SLEEP_FOREVER}, 16);
      rst_pin_n = 1'b0;
      repeat (4) @(negedge clk);
      rst_pin_n = 1'b1;
      repeat (10) @(negedge clk);
      chk_state("pin wake", 2'b00, {asleep, sleep_fv});
      nap(8'h00);
      nap(8'h01);
      nap(8'h05);
      nap(8'hFE);
      nap(8'(($random(seed) & 15) + 2));
      results();
   end
endmodule : sleep_and_diag_status_bench
